// File: core/spi_cfg_host.sv
// Serial configuration host that drives the ADC three-wire port
//
// Overview of operation
// - Transfers only happen while chip select is driven low.
// - Frame starts on chip select falling; first rising clock is bit one.
// - Chip select may stay low to stream successive transfers.
// - Chip select may rise between bytes to stall; resume at next byte.
// - Every frame opens with sixteen instruction bits.
// - First frame bit chooses read (one) or write (zero); with control bit 1 set the host sends instruction bit 0 first.
// - On a read the host releases the data line when readback starts.
// - Data after the instruction is in 8-bit words.
// - Strap mode needs chip select tied high to disable the port.
// - Keep power-down and output-enable at defaults under serial control.
// - Keep the port idle when full converter performance is needed.
//
// Register map, byte offsets on the bus
//   0x0 control
//      bit 0  start a frame; reads back as zero
//      bit 1  shift least significant bit first
//      bit 2  keep chip select low between frames (streaming)
//      bit 3  raise chip select after every byte but the last until software clears this bit
//      bit 4  strap mode: no frames, shared pins carry static levels
//      bit 5  strap level of the data pin (stabilizer), set after reset
//      bit 6  strap level of the clock pin (output format)
//      bit 7  level of the output enable pin
//      bit 8  level of the power-down pin
//   0x4 instruction word sent at the head of the next frame
//      bit 15  read when set, write when clear
//      bits 14:13  data bytes minus one
//      bits 12:0  register address in the converter
//   0x8 write: data bytes for the frame, byte k in bits 8k+7:8k
//       read: read-back bytes of the last frame in the same places
//   0xC status
//      bit 0  busy, from start until the frame has closed
//      bit 1  shifting, busy and not stalled
//      bit 2  stalled with chip select high
//      bits 5:3  frame phase
//   Unmapped offsets read as zero and ignore writes; every access is acknowledged.
//
// Bus
//   Classic single cycles. A request is taken on the first edge with cycle and
//   strobe high and no acknowledge pending; the acknowledge follows one cycle
//   later for one cycle, with read data registered beside it.
//   Byte enables apply to the control register only.
//
// Reset
//   Synchronous and active high; chip select leaves reset high, clock low,
//   data pin released, control register at its reset values.
//   The first bus request is taken on the first edge after reset falls.
//
// Frame timing
//   A frame begins with chip select falling one cycle after the start is taken.
//   A serial bit is a low half, a high half and one bookkeeping cycle.
//   The host changes its data bit only while the serial clock is low.
//   Read-back bits are taken as the serial clock falls, from the filtered pin.
//   The pin filter adds four cycles of lag, well inside one half period.
//   Writes to the instruction and data registers are ignored while a frame runs,
//   so software must poll the busy bit before loading the next frame.
//
// Stall and resume
//   With the stall bit set the frame pauses after every whole byte but the last,
//   instruction bytes included. Chip select rises and the frame counters hold.
//   Clearing the stall bit lowers chip select and the frame goes on at the
//   next bit, so the converter sees one byte boundary per pause.
//
// Streaming
//   With the hold bit set chip select stays low after the frame ends and the
//   next start continues on the same select; clearing the bit raises it.
//
// Pins
//   Chip select and the serial clock are always driven by the host.
//   The data pin is released during read-back bytes and while stalled.
//   In strap mode chip select stays high and the clock and data pins carry levels.
//   The output enable and power-down pins follow their control bits in both modes.
//
// Limitations
//   A frame carries at most four data bytes; longer runs take several frames.
//   Strap levels are applied only while no frame is in progress.
//   Only one converter is reached; there are no select lines for more devices.
`timescale 1ns/1ps
module spi_cfg_host #(
   parameter int HALF_CYC = spi_cfg_host_pkg::SCLK_HALF_CYC
) (
   // Clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   // Wishbone slave
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [spi_cfg_host_pkg::ADDR_W-1:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   // Device pins
   output logic CHIP_SELECT_N_OUT,
   output logic SERIAL_CLOCK_FORMAT_PIN_OUT,
   output logic SERIAL_DATA_STABILIZER_PIN_OUT,
   output logic SERIAL_DATA_STABILIZER_PIN_OE_N_OUT,
   input wire logic SERIAL_DATA_STABILIZER_PIN_IN,
   output logic OUTPUT_ENABLE_N_OUT,
   output logic POWER_DOWN_PIN_OUT
);
   import spi_cfg_host_pkg::*;

   state_s r;
   state_s next_r;

   // Data bit position within the current word for the chosen order
   function automatic logic [2:0] bit_pos(input logic [2:0] idx, input logic lsb_first);
      bit_pos = lsb_first ? idx : 3'(WORD_BITS - 1) - idx;
   endfunction : bit_pos

   // Bytes in the data phase from the word-length bits
   function automatic logic [2:0] byte_count(input logic [1:0] wl);
      byte_count = (wl == 2'b11) ? 3'(MAX_BYTES) : 3'(wl) + 3'h1;
   endfunction : byte_count

   // True once the instruction bits have all been shifted
   function automatic logic in_data_phase(input logic [5:0] cnt);
      in_data_phase = (cnt >= 6'(INSTR_BITS));
   endfunction : in_data_phase

   // True on the last system cycle of a serial clock half period
   function automatic logic half_end(input logic [2:0] cnt);
      half_end = (cnt == 3'(HALF_CYC - 1));
   endfunction : half_end

   // Bit to present on the data pin for the current frame position
   function automatic logic tx_bit(input state_s s);
      logic [5:0] dbit;
      logic [3:0] ipos;
      logic [2:0] dpos;
      dbit = s.bitcnt - 6'(INSTR_BITS);
      ipos = s.ctrl[CTRL_LSB_FIRST] ? 4'(s.bitcnt) : 4'(INSTR_BITS - 1) - 4'(s.bitcnt);
      dpos = bit_pos(dbit[2:0], s.ctrl[CTRL_LSB_FIRST]);
      if (in_data_phase(s.bitcnt)) begin
         tx_bit = s.wdata[{dbit[4:3], dpos}];
      end else begin
         tx_bit = s.instr[ipos];
      end
   endfunction : tx_bit

   // Read multiplexer for the bus registers
   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] adr, input state_s s);
      logic [31:0] word;
      word = 32'h0;
      if (adr == REG_CTRL) begin
         word = {23'h0, s.ctrl};
      end else if (adr == REG_INSTR) begin
         word = {16'h0, s.instr};
      end else if (adr == REG_WDATA) begin
         word = s.rdata;
      end else if (adr == REG_STATUS) begin
         word = {26'h0, s.phase, s.resume, s.busy && !s.resume, s.busy};
      end
      read_word = word;
   endfunction : read_word

   logic sdi;
   logic frame_bits_done;
   logic [5:0] data_bit;
   logic [1:0] byte_idx;
   logic [2:0] in_byte;
   logic is_read;
   logic wb_req;

   assign sdi = r.sdi;
   assign is_read = r.instr[INSTR_RW];
   assign data_bit = r.bitcnt - 6'(INSTR_BITS);
   assign byte_idx = data_bit[4:3];
   assign in_byte = data_bit[2:0];
   assign frame_bits_done = (r.bitcnt == 6'(INSTR_BITS) + {r.nbytes, 3'h0} - 6'h1);
   assign wb_req = WB_CYC_IN && WB_STB_IN && !r.ack;

   always_comb begin
      logic [2:0] dpos;
      logic out_bit;
      dpos = 3'h0;
      out_bit = 1'b0;
      next_r = r;
      next_r.ack = 1'b0;
      // Three-stage input sampling of the read-back line
      next_r.sdi_sync = {r.sdi_sync[1:0], SERIAL_DATA_STABILIZER_PIN_IN};
      // The read-back level changes only once the last two stages agree
      if (r.sdi_sync[2] == r.sdi_sync[1]) begin
         next_r.sdi = r.sdi_sync[2];
      end
      next_r.done = 1'b0;

      if (wb_req) begin
         next_r.ack = 1'b1;
         if (WB_WE_IN) begin
            if (WB_ADR_IN == REG_CTRL) begin
               if (WB_SEL_IN[0]) begin
                  next_r.ctrl[7:0] = WB_DAT_IN[7:0];
               end
               if (WB_SEL_IN[1]) begin
                  next_r.ctrl[8] = WB_DAT_IN[8];
               end
               next_r.ctrl[CTRL_START] = 1'b0;
               if (WB_SEL_IN[0] && WB_DAT_IN[CTRL_START] && !r.busy) begin
                  next_r.busy = 1'b1;
               end
            end else if (WB_ADR_IN == REG_INSTR) begin
               if (!r.busy) begin
                  next_r.instr = WB_DAT_IN[15:0];
               end
            end else if (WB_ADR_IN == REG_WDATA) begin
               if (!r.busy) begin
                  next_r.wdata = WB_DAT_IN;
               end
            end
         end else begin
            next_r.dat_o = read_word(WB_ADR_IN, r);
         end
      end

      // Serial bit to present for the current position
      out_bit = tx_bit(r);

      case (r.phase)
         ST_IDLE: begin
            // Port stays quiet until software starts a frame
            next_r.pins.sclk = 1'b0;
            next_r.pins.sdo_oe_n = 1'b1;
            next_r.pins.cs_n = !r.ctrl[CTRL_HOLD_CS];
            if (r.busy && !r.ctrl[CTRL_STRAP]) begin
               next_r.nbytes = byte_count(r.instr[INSTR_W1:INSTR_W0]);
               next_r.bitcnt = 6'h0;
               next_r.rdata = 32'h0;
               next_r.div = 3'h0;
               next_r.pins.cs_n = 1'b0;
               next_r.phase = ST_LOW;
            end else if (r.busy) begin
               next_r.busy = 1'b0;
            end
         end
         ST_LOW: begin
            // Host drives instruction and write data; releases line on read data
            next_r.pins.sdo = out_bit;
            next_r.pins.sdo_oe_n = is_read && in_data_phase(r.bitcnt);
            next_r.div = r.div + 3'h1;
            if (half_end(r.div)) begin
               next_r.div = 3'h0;
               next_r.pins.sclk = 1'b1;
               next_r.phase = ST_HIGH;
            end
         end
         ST_HIGH: begin
            // Read-back bit is taken as the clock falls
            next_r.div = r.div + 3'h1;
            if (half_end(r.div)) begin
               next_r.div = 3'h0;
               next_r.pins.sclk = 1'b0;
               if (is_read && in_data_phase(r.bitcnt)) begin
                  dpos = bit_pos(in_byte, r.ctrl[CTRL_LSB_FIRST]);
                  next_r.rdata[{byte_idx, dpos}] = sdi;
               end
               next_r.phase = ST_NEXT;
            end
         end
         ST_NEXT: begin
            // Bookkeeping cycle: count the bit, then end, stall or go on
            next_r.bitcnt = r.bitcnt + 6'h1;
            if (frame_bits_done) begin
               next_r.phase = ST_DONE;
            end else if (r.ctrl[CTRL_STALL] && r.bitcnt[2:0] == 3'h7) begin
               next_r.pins.cs_n = 1'b1;
               next_r.pins.sdo_oe_n = 1'b1;
               next_r.resume = 1'b1;
               next_r.phase = ST_STALL;
            end else begin
               next_r.phase = ST_LOW;
            end
         end
         ST_STALL: begin
            // Frame state is kept; software clears the stall bit to resume
            if (!r.ctrl[CTRL_STALL]) begin
               next_r.pins.cs_n = 1'b0;
               next_r.resume = 1'b0;
               next_r.phase = ST_LOW;
            end
         end
         ST_DONE: begin
            // Close the frame; chip select follows the hold bit
            next_r.pins.sdo_oe_n = 1'b1;
            next_r.pins.cs_n = !r.ctrl[CTRL_HOLD_CS];
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.phase = ST_IDLE;
         end
         default: begin
            next_r.phase = ST_IDLE;
         end
      endcase

      // Strap mode: chip select high, shared pins become static levels
      if (r.ctrl[CTRL_STRAP] && r.phase == ST_IDLE) begin
         next_r.pins.cs_n = 1'b1;
         next_r.pins.sdo = r.ctrl[CTRL_DCS];
         next_r.pins.sdo_oe_n = 1'b0;
         next_r.pins.sclk = r.ctrl[CTRL_DFS];
      end
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         r <= '0;
         r.phase <= ST_IDLE;
         r.ctrl <= CTRL_RESET;
         r.pins.cs_n <= 1'b1;
         r.pins.sdo_oe_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign WB_DAT_OUT = r.dat_o;
   assign WB_ACK_OUT = r.ack;
   assign CHIP_SELECT_N_OUT = r.pins.cs_n;
   assign SERIAL_CLOCK_FORMAT_PIN_OUT = r.pins.sclk;
   assign SERIAL_DATA_STABILIZER_PIN_OUT = r.pins.sdo;
   assign SERIAL_DATA_STABILIZER_PIN_OE_N_OUT = r.pins.sdo_oe_n;
   // Static control pins act in both modes
   assign OUTPUT_ENABLE_N_OUT = r.ctrl[CTRL_OE_N];
   assign POWER_DOWN_PIN_OUT = r.ctrl[CTRL_POWER_DOWN_PIN];
endmodule : spi_cfg_host

// File: core/spi_cfg_host_pkg.sv
// Package for the ADC serial configuration host controller
package spi_cfg_host_pkg;
   // Wishbone register offsets (byte addresses)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_INSTR = 4'h4;
   localparam logic [3:0] REG_WDATA = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hC;
   localparam int ADDR_W = 4;
   // Control register fields
   localparam int CTRL_START = 0;
   localparam int CTRL_LSB_FIRST = 1;
   localparam int CTRL_HOLD_CS = 2;
   localparam int CTRL_STALL = 3;
   localparam int CTRL_STRAP = 4;
   localparam int CTRL_DCS = 5;
   localparam int CTRL_DFS = 6;
   localparam int CTRL_OE_N = 7;
   localparam int CTRL_POWER_DOWN_PIN = 8;
   localparam logic [8:0] CTRL_RESET = 9'h020;
   // Instruction field positions
   localparam int INSTR_RW = 15;
   localparam int INSTR_W1 = 14;
   localparam int INSTR_W0 = 13;
   localparam int INSTR_BITS = 16;
   localparam int WORD_BITS = 8;
   localparam int MAX_BYTES = 4;
   // Serial clock: 100 MHz / (2*5 + 1), about 9.09 MHz
   localparam int SCLK_HALF_NS = 50;
   localparam int CLK_NS = 10;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOW = 3'b001,
      ST_HIGH = 3'b011,
      ST_NEXT = 3'b010,
      ST_STALL = 3'b110,
      ST_DONE = 3'b100
   } phase_e;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic sdo;
      logic sdo_oe_n;
   } pins_s;

   typedef struct packed {
      phase_e phase;
      logic [8:0] ctrl;
      logic [15:0] instr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [2:0] nbytes;
      logic [5:0] bitcnt;
      logic [2:0] div;
      logic busy;
      logic done;
      logic resume;
      logic ack;
      logic [31:0] dat_o;
      pins_s pins;
      logic [2:0] sdi_sync;
      logic sdi;
   } state_s;
endpackage : spi_cfg_host_pkg

// File: tb/adc_port_model.sv
// Behavioural model of the converter's serial configuration port
`timescale 1ns/1ps
module adc_port_model (
   // Pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdio,
   output logic drv
);
   logic [7:0] mem [0:15];
   logic [15:0] instr = 16'h0;
   logic [7:0] sh = 8'h0;
   int nbit = 0;
   initial drv = 1'b1;
   // Frame state survives a raised select, so a stall resumes mid-frame
   always @(posedge sclk) if (!cs_n) begin
      if (nbit < 16) instr = {instr[14:0], sdio};
      sh = {sh[6:0], sdio};
      nbit++;
      if (nbit > 16 && nbit % 8 == 0 && !instr[15]) mem[instr[3:0] + 4'((nbit - 24) / 8)] = sh;
      if (nbit == 16 + 8 * (instr[14:13] + 1)) nbit = 0;
   end
   // Released line shows the inverse of its last level
   task automatic put;
      if (!cs_n && instr[15] && nbit >= 16) drv = mem[instr[3:0] + 4'((nbit - 16) / 8)][7 - nbit % 8];
      else drv = ~drv;
   endtask : put
   always @(negedge sclk) put();
   always @(cs_n) put();
endmodule : adc_port_model

// File: tb/spi_cfg_host_assertions.sv
// Checker for the bus answer and serial pins of the host
`timescale 1ns/1ps
module spi_cfg_host_assertions #(
   parameter int HALF_CYC = 5
) (
   // Bus
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_ACK_OUT,
   // Pins
   input wire logic CHIP_SELECT_N_OUT,
   input wire logic SERIAL_CLOCK_FORMAT_PIN_OUT,
   input wire logic SERIAL_DATA_STABILIZER_PIN_OUT,
   input wire logic SERIAL_DATA_STABILIZER_PIN_OE_N_OUT
);
   logic cs_n;
   logic sck;
   logic oe_n;
   logic [3:0] hi;
   assign cs_n = CHIP_SELECT_N_OUT;
   assign sck = SERIAL_CLOCK_FORMAT_PIN_OUT;
   assign oe_n = SERIAL_DATA_STABILIZER_PIN_OE_N_OUT;
   // Length of the clock high phase inside a frame
   always_ff @(posedge CLK_SYS_IN) begin
      hi <= (sck && !cs_n && !RST_IN) ? hi + 4'h1 : 4'h0;
   end
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);
   sequence s_lead;
      !sck [*4] ##[1:8] sck;
   endsequence
   a_reset_idle:
      assert property (disable iff (1'b0) RST_IN |=> cs_n && !sck && oe_n && !WB_ACK_OUT) else $error("not idle");
   a_ack_answer:
      assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT) else $error("ack late");
   a_ack_pulse:
      assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack too long");
   a_frame_lead:
      assert property ($fell(cs_n) |-> s_lead) else $error("no clock after select");
   a_sclk_high:
      assert property ($fell(sck) && !cs_n |-> hi == 4'(HALF_CYC)) else $error("clock high phase");
   a_select_end:
      assert property ($rose(cs_n) |-> !sck) else $error("select rose in high phase");
   a_data_steady:
      assert property (sck && !cs_n && !oe_n |-> $stable(SERIAL_DATA_STABILIZER_PIN_OUT)) else $error("data moved");
   a_turn_steady:
      assert property (sck && !cs_n |-> $stable(oe_n)) else $error("direction moved");
endmodule : spi_cfg_host_assertions
bind spi_cfg_host spi_cfg_host_assertions #(.HALF_CYC(HALF_CYC)) u_chk (.*);

// File: tb/spi_cfg_host_bench.sv
// Self-checking bench for the serial configuration host
`timescale 1ns/1ps
module spi_cfg_host_bench;
   import spi_cfg_host_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] dout, rdat;
   logic ack, cs_n, sck, sdo, oe_n, output_enable_n, pd, drv;
   int n_errors = 0;
   int compares = 0;
   always #5 clk = ~clk;
   spi_cfg_host u_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack),
      .CHIP_SELECT_N_OUT(cs_n), .SERIAL_CLOCK_FORMAT_PIN_OUT(sck), .SERIAL_DATA_STABILIZER_PIN_OUT(sdo),
      .SERIAL_DATA_STABILIZER_PIN_OE_N_OUT(oe_n), .SERIAL_DATA_STABILIZER_PIN_IN(oe_n ? drv : sdo),
      .OUTPUT_ENABLE_N_OUT(output_enable_n), .POWER_DOWN_PIN_OUT(pd));
   adc_port_model u_dev (.cs_n(cs_n), .sclk(sck), .sdio(oe_n ? drv : sdo), .drv(drv));
   task chk(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want) begin
         n_errors++;
         $display("MISMATCH %0t got %h want %h", $time, got, want);
      end
   endtask : chk
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do @(posedge clk); while (ack !== 1'b1);
      rdat = dout;
      {cyc, stb} <= 2'b00;
   endtask : wb
   task wait_idle;
      do wb(1'b0, REG_STATUS, 32'h0); while (rdat[0] !== 1'b0);
   endtask : wait_idle
   task xfer(input logic [15:0] ins, input logic [31:0] d, input logic [8:0] c);
      wb(1'b1, REG_INSTR, {16'h0, ins});
      wb(1'b1, REG_WDATA, d);
      wb(1'b1, REG_CTRL, {23'h0, c} | 32'h1);
      wait_idle();
      wb(1'b0, REG_WDATA, 32'h0);
   endtask : xfer
   task t_reset;
      chk({cs_n, output_enable_n, pd}, 32'h4);
      wb(1'b0, REG_CTRL, 32'h0);
      chk(rdat, {23'h0, CTRL_RESET});
      wb(1'b0, 4'h2, 32'h0);
      chk(rdat, 32'h0);
      $display("reset test done");
   endtask : t_reset
   task t_words;
      logic [15:0] ins;
      for (int w = 0; w < 4; w++) begin
         ins = {1'b0, 2'(w), 13'h004};
         xfer(ins, 32'hC35A96E1, 9'h0);
         chk(u_dev.instr, ins);
         chk(u_dev.nbit, 32'h0);
         xfer(ins | 16'h8000, 32'h0, 9'h0);
         chk(rdat, 32'hC35A96E1 & (32'hFFFFFFFF >> (8 * (3 - w))));
      end
      $display("word length test done");
   endtask : t_words
   task t_order;
      xfer(16'h00A8, 32'h01, 9'h002);
      chk(u_dev.instr, 32'h1500);
      xfer(16'h8000, 32'h0, 9'h0);
      chk(rdat, 32'h80);
      $display("bit order test done");
   endtask : t_order
   task t_stream;
      xfer(16'h0009, 32'h5A, 9'h004);
      chk(cs_n, 1'b0);
      xfer(16'h8009, 32'h0, 9'h004);
      chk(rdat, 32'h5A);
      wb(1'b1, REG_CTRL, 32'h0);
      $display("stream test done");
   endtask : t_stream
   task t_stall;
      wb(1'b1, REG_INSTR, 32'h200C);
      wb(1'b1, REG_WDATA, 32'hBEEF);
      wb(1'b1, REG_CTRL, 32'h9);
      do wb(1'b0, REG_STATUS, 32'h0); while (rdat[2] !== 1'b1);
      chk(cs_n, 1'b1);
      wb(1'b1, REG_CTRL, 32'h0);
      wait_idle();
      xfer(16'hA00C, 32'h0, 9'h0);
      chk(rdat, 32'hBEEF);
      $display("stall test done");
   endtask : t_stall
   task t_pins;
      wb(1'b1, REG_CTRL, 32'h180);
      repeat (2) @(posedge clk);
      chk({cs_n, output_enable_n, pd}, 32'h7);
      wb(1'b1, REG_CTRL, 32'h1D0);
      repeat (2) @(posedge clk);
      chk({cs_n, sck, sdo, oe_n, output_enable_n, pd}, 32'h33);
      wb(1'b1, REG_CTRL, 32'h030);
      repeat (2) @(posedge clk);
      chk({cs_n, sck, sdo, oe_n, output_enable_n, pd}, 32'h28);
      $display("pin test done");
   endtask : t_pins
   task end_of_test;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_words();
      t_order();
      t_stream();
      t_stall();
      t_pins();
      end_of_test();
   end
   initial begin
      #400us;
      n_errors++;
      end_of_test();
   end
endmodule : spi_cfg_host_bench
